// *** lsed_pkg.sv ***
package lsed_pkg;
  // Oscillator and system clock
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_PERIOD_NS     = 3700;
  localparam int unsigned OSC_CYCLES        = OSC_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int unsigned OSC_CNT_W         = 9;
  localparam int unsigned SHIFT_HIGH_CYCLES = OSC_CYCLES / 2;

  // Common lines and duties
  localparam int unsigned NUM_COMMONS  = 16;
  localparam logic [4:0]  DUTY_ONE_5X8 = 5'h08;
  localparam logic [4:0]  DUTY_ONE_5X10 = 5'h0B;
  localparam logic [4:0]  DUTY_TWO_5X8 = 5'h10;

  // Segments and digits
  localparam int unsigned SEGS_PER_DIGIT   = 5;
  localparam int unsigned OWN_DIGITS_ONE   = 8;
  localparam int unsigned OWN_DIGITS_TWO   = 16;
  localparam int unsigned OWN_SEGS         = 40;
  localparam int unsigned MAX_CHARS        = 80;
  localparam int unsigned MAX_EXT_ONE      = 9;
  localparam int unsigned MAX_EXT_TWO      = 4;
  localparam int unsigned EXT_DIGITS_PER   = 8;

  // Serial bits per row: 40 characters in one-line mode, 32 in two-line mode
  localparam logic [8:0]  SHIFT_BITS_ONE   = 9'h0C8;
  localparam logic [8:0]  SHIFT_BITS_TWO   = 9'h0A0;
  localparam int unsigned SHIFT_CNT_W      = 9;

  // Clocks per common row of oscillator periods
  localparam logic [8:0]  OSC_PER_ROW      = 9'h0D0;

  // Common drive codes
  localparam logic [1:0]  COM_NONSEL       = 2'h0;
  localparam logic [1:0]  COM_SEL          = 2'h1;

  typedef enum logic [2:0]
  {
    LSED_IDLE  = 3'h1,
    LSED_SHIFT = 3'h2,
    LSED_LATCH = 3'h4
  } lsed_state_t;
endpackage : lsed_pkg

// *** lsed_osc_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsed_osc_tick
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  logic [lsed_pkg::OSC_CNT_W-1:0] count;

  // Oscillator tick from system clock
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count  <= '0;
      o_tick <= 1'b0;
    end
    else if (count == lsed_pkg::OSC_CNT_W'(lsed_pkg::OSC_CYCLES - 1))
    begin
      count  <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      count  <= count + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // lsed_osc_tick
`default_nettype wire

// *** lsed_duty_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsed_duty_decode
(
  input  wire logic       i_two_lines,
  input  wire logic       i_font_5x10,
  output logic [4:0]      o_commons,
  output logic [8:0]      o_shift_bits
);
  // Font ignored in two-line mode
  // No 5x10 two-line mode
  // Bits beyond own 5-segment digits
  always_comb
  begin
    if (i_two_lines)
    begin
      o_commons    = lsed_pkg::DUTY_TWO_5X8;
      o_shift_bits = lsed_pkg::SHIFT_BITS_TWO;
    end
    else if (i_font_5x10)
    begin
      o_commons    = lsed_pkg::DUTY_ONE_5X10;
      o_shift_bits = lsed_pkg::SHIFT_BITS_ONE;
    end
    else
    begin
      o_commons    = lsed_pkg::DUTY_ONE_5X8;
      o_shift_bits = lsed_pkg::SHIFT_BITS_ONE;
    end
  end
endmodule // lsed_duty_decode
`default_nettype wire

// *** lsed_scan.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsed_scan
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_two_lines,
  input  wire logic        i_font_5x10,
  input  wire logic        i_seg_data,
  output logic [15:0]      o_com_sel,
  output logic [4:0]       o_row,
  output logic [4:0]       o_duty,
  output logic             o_row_latch_clock,
  output logic             o_segment_shift_clock,
  output logic             o_frame_alt,
  output logic             o_serial_data,
  output logic [8:0]       o_bit_index
);
  logic                                 tick;
  logic [4:0]                           commons;
  logic [8:0]                           shift_bits;
  logic [4:0]                           row;
  logic [8:0]                           osc_count;
  logic [8:0]                           bit_count;
  logic [8:0]                           hi_count;
  lsed_pkg::lsed_state_t                state;
  lsed_pkg::lsed_state_t                next_state;
  logic                                 row_done;

  lsed_osc_tick u_tick
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .o_tick    (tick)
  );

  // Mode from program inputs only
  lsed_duty_decode u_decode
  (
    .i_two_lines  (i_two_lines),
    .i_font_5x10  (i_font_5x10),
    .o_commons    (commons),
    .o_shift_bits (shift_bits)
  );

  function automatic logic [15:0] lsed_onehot(input logic [4:0] idx, input logic [4:0] n);
    logic [15:0] v;
    v = '0;
    for (int k = 0; k < 16; k++)
    begin
      // Only active commons may be selected
      if (idx == 5'(k) && 5'(k) < n)
      begin
        v[k] = 1'b1;
      end
    end
    return v;
  endfunction

  assign row_done = tick && (osc_count == lsed_pkg::OSC_PER_ROW - 9'h001);

  // Row timing from oscillator ticks
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      osc_count <= '0;
    end
    else if (row_done)
    begin
      osc_count <= '0;
    end
    else if (tick)
    begin
      osc_count <= osc_count + 9'h001;
    end
  end

  // Row scan within duty
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      row         <= '0;
      o_frame_alt <= 1'b0;
    end
    else if (row_done)
    begin
      if (row >= commons - 5'h01)
      begin
        row         <= '0;
        o_frame_alt <= ~o_frame_alt;
      end
      else
      begin
        row <= row + 5'h01;
      end
    end
  end

  // Common drive
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_com_sel <= '0;
      o_row     <= '0;
      o_duty    <= lsed_pkg::DUTY_ONE_5X8;
    end
    else
    begin
      o_com_sel <= lsed_onehot(row, commons);
      o_row     <= row;
      o_duty    <= commons;
    end
  end

  // Serial transfer state machine
  always_comb
  begin
    next_state = state;
    unique case (state)
      lsed_pkg::LSED_IDLE:
      begin
        if (tick)
        begin
          next_state = lsed_pkg::LSED_SHIFT;
        end
      end
      lsed_pkg::LSED_SHIFT:
      begin
        // Bit count per row fixed by mode
        if (tick && bit_count == shift_bits && !o_segment_shift_clock)
        begin
          next_state = lsed_pkg::LSED_LATCH;
        end
      end
      lsed_pkg::LSED_LATCH:
      begin
        if (row_done)
        begin
          next_state = lsed_pkg::LSED_IDLE;
        end
      end
      default:
      begin
        next_state = lsed_pkg::LSED_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= lsed_pkg::LSED_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Shift one bit per oscillator tick, same in every mode
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bit_count             <= '0;
      hi_count              <= '0;
      o_segment_shift_clock <= 1'b0;
      o_serial_data         <= 1'b0;
      o_bit_index           <= '0;
    end
    else if (o_segment_shift_clock)
    begin
      // High for half an oscillator period
      if (hi_count == 9'(lsed_pkg::SHIFT_HIGH_CYCLES - 1))
      begin
        hi_count              <= '0;
        o_segment_shift_clock <= 1'b0;
      end
      else
      begin
        hi_count <= hi_count + 9'h001;
      end
    end
    else if (state == lsed_pkg::LSED_SHIFT && tick && bit_count < shift_bits)
    begin
      // Limit keeps at most 40 chars (200 bits)
      o_serial_data         <= i_seg_data;
      o_bit_index           <= bit_count;
      o_segment_shift_clock <= 1'b1;
      bit_count             <= bit_count + 9'h001;
    end
    else if (state == lsed_pkg::LSED_IDLE)
    begin
      bit_count <= '0;
    end
  end

  // One latch pulse per common row
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_row_latch_clock <= 1'b0;
    end
    else
    begin
      o_row_latch_clock <= row_done;
    end
  end
endmodule // lsed_scan
`default_nettype wire

// *** lsed_scan_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsed_scan_asserts
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_two_lines,
  input wire logic        i_font_5x10,
  input wire logic        i_seg_data,
  input wire logic [15:0] o_com_sel,
  input wire logic [4:0]  o_row,
  input wire logic [4:0]  o_duty,
  input wire logic        o_row_latch_clock,
  input wire logic        o_segment_shift_clock,
  input wire logic        o_frame_alt,
  input wire logic        o_serial_data,
  input wire logic [8:0]  o_bit_index
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [9:0] hi_cnt;
  // Shift clock high time
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      hi_cnt <= 10'h000;
    else
      hi_cnt <= o_segment_shift_clock ? hi_cnt + 10'h001 : 10'h000;
  property p_com_range; (o_com_sel >> o_duty) == 16'h0000; endproperty
  a_com_range: assert property (p_com_range) else $error("common above duty");
  property p_onehot; $onehot0(o_com_sel); endproperty
  a_onehot: assert property (p_onehot) else $error("two commons selected");
  property p_duty; o_duty inside {5'h08, 5'h0B, 5'h10}; endproperty
  a_duty: assert property (p_duty) else $error("bad duty");
  property p_latch; o_row_latch_clock |=> !o_row_latch_clock; endproperty
  a_latch: assert property (p_latch) else $error("latch too long");
  property p_step; o_row_latch_clock |=> o_row == 5'h00 || o_row == $past(o_row) + 5'h01; endproperty
  a_step: assert property (p_step) else $error("row skipped");
  property p_com; o_row_latch_clock |=> o_com_sel == 16'h0001 << o_row; endproperty
  a_com: assert property (p_com) else $error("common not row");
  property p_high; $fell(o_segment_shift_clock) |-> hi_cnt == 10'h0B9; endproperty
  a_high: assert property (p_high) else $error("shift high time");
  property p_bits; o_bit_index < 9'h0C8; endproperty
  a_bits: assert property (p_bits) else $error("bit index too big");
  c_latch: cover property (o_row_latch_clock);
  c_shift: cover property ($rose(o_segment_shift_clock));
  c_two: cover property (o_duty == 5'h10);
endmodule // lsed_scan_asserts
bind lsed_scan lsed_scan_asserts i_lsed_scan_asserts
(
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_two_lines(i_two_lines),
  .i_font_5x10(i_font_5x10), .i_seg_data(i_seg_data), .o_com_sel(o_com_sel),
  .o_row(o_row), .o_duty(o_duty), .o_row_latch_clock(o_row_latch_clock),
  .o_segment_shift_clock(o_segment_shift_clock), .o_frame_alt(o_frame_alt),
  .o_serial_data(o_serial_data), .o_bit_index(o_bit_index)
);
`default_nettype wire

// *** lsed_ext_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsed_ext_model
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_shift,
  input  wire logic       i_latch,
  input  wire logic       i_data,
  input  wire logic [8:0] i_index,
  output logic            o_seg_data,
  output logic [8:0]      o_bits,
  output logic [8:0]      o_ones
);
  logic       shift_q = 1'b0;
  logic [8:0] bits    = 9'h000;
  logic [8:0] ones    = 9'h000;
  // Display data offered per bit
  assign o_seg_data = bits[0] ^ bits[3];
  // One bit per shift pulse, row total at latch
  always_ff @(posedge i_sys_clk)
  begin
    shift_q <= i_shift;
    if (i_latch)
    begin
      o_bits <= bits;
      o_ones <= ones;
      bits   <= 9'h000;
      ones   <= 9'h000;
    end
    else if (!i_shift && shift_q)
    begin
      bits <= bits + 9'h001;
      // Count bits whose data matches their index
      ones <= ones + {8'h00, i_data == (i_index[0] ^ i_index[3])};
    end
  end
endmodule // lsed_ext_model
`default_nettype wire

// *** lsed_scan_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsed_scan_test;
  logic        i_sys_clk;
  logic        i_rst;
  logic        i_two_lines;
  logic        i_font_5x10;
  logic        i_seg_data;
  logic [15:0] o_com_sel;
  logic [4:0]  o_row;
  logic [4:0]  o_duty;
  logic        o_row_latch_clock;
  logic        o_segment_shift_clock;
  logic        o_frame_alt;
  logic        o_serial_data;
  logic [8:0]  o_bit_index;
  logic [8:0]  m_bits;
  logic [8:0]  m_ones;
  int          n_errors;
  int          n_checks;
  lsed_scan i_lsed_scan
  (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_two_lines(i_two_lines),
    .i_font_5x10(i_font_5x10), .i_seg_data(i_seg_data), .o_com_sel(o_com_sel),
    .o_row(o_row), .o_duty(o_duty), .o_row_latch_clock(o_row_latch_clock),
    .o_segment_shift_clock(o_segment_shift_clock), .o_frame_alt(o_frame_alt),
    .o_serial_data(o_serial_data), .o_bit_index(o_bit_index)
  );
  lsed_ext_model i_lsed_ext_model
  (
    .i_sys_clk(i_sys_clk), .i_shift(o_segment_shift_clock), .i_latch(o_row_latch_clock),
    .i_data(o_serial_data), .i_index(o_bit_index), .o_seg_data(i_seg_data),
    .o_bits(m_bits), .o_ones(m_ones)
  );
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Values right after reset
  task automatic t_reset();
    check("duty", {11'h000, o_duty}, 16'h0008);
    check("com_sel", o_com_sel, 16'h0000);
    check("frame", {15'h0000, o_frame_alt}, 16'h0000);
  endtask
  // Two lines, font bit set: one full row
  task automatic t_row();
    int   rises;
    int   width;
    int   exp;
    logic prev;
    rises = 0;
    width = 0;
    prev  = 1'b0;
    exp   = lsed_pkg::MAX_EXT_TWO * lsed_pkg::EXT_DIGITS_PER * lsed_pkg::SEGS_PER_DIGIT;
    for (int n = 0; n < 80000 && o_row_latch_clock !== 1'b1; n++)
    begin
      @(negedge i_sys_clk);
      if (o_segment_shift_clock === 1'b1 && !prev)
        rises++;
      if (o_segment_shift_clock === 1'b1 && rises == 1)
        width++;
      prev = (o_segment_shift_clock === 1'b1);
    end
    if (o_row_latch_clock !== 1'b1)
    begin
      n_errors++;
      results();
    end
    repeat (2) @(negedge i_sys_clk);
    check("shift bits", 16'(rises), 16'(exp));
    check("high width", 16'(width), 16'(lsed_pkg::SHIFT_HIGH_CYCLES));
    check("driver bits", {7'h00, m_bits}, 16'(exp));
    check("driver data", {7'h00, m_ones}, 16'(exp));
    check("last index", {7'h00, o_bit_index}, 16'(exp - 1));
    check("duty", {11'h000, o_duty}, 16'h0010);
    check("latch", {15'h0000, o_row_latch_clock}, 16'h0000);
  endtask
  initial
  begin
    n_errors    = 0;
    n_checks    = 0;
    i_rst       = 1'b1;
    i_two_lines = 1'b1;
    i_font_5x10 = 1'b1;
    repeat (12) @(negedge i_sys_clk);
    i_rst = 1'b0;
    t_reset();
    t_row();
    results();
  end
endmodule // lsed_scan_test
`default_nettype wire
